/* src/sbfr_top.sv */
module sbfr_top
   import sbfr_pkg::*;
#(
   parameter int P_BUF_BYTES = SBFR_BUF_BYTES,
   parameter logic [6:0] P_DIO_DUM_BUF = SBFR_DIO_DUM_BUF,
   parameter logic [6:0] P_DIO_DUM_SEQ = SBFR_DIO_DUM_SEQ,
   parameter logic [6:0] P_DIO4_DUM_BUF = SBFR_DIO4_DUM_BUF,
   parameter logic [6:0] P_DIO4_DUM_SEQ = SBFR_DIO4_DUM_SEQ,
   parameter logic [6:0] P_QIO_DUM_BUF = SBFR_QIO_DUM_BUF,
   parameter logic [6:0] P_QIO_DUM_SEQ = SBFR_QIO_DUM_SEQ
)
(
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // Serial link pins
   input wire logic I_CS_N,
   input wire logic I_SCLK,
   input wire logic [3:0] I_IO,
   output logic [3:0] O_IO,
   output logic [3:0] O_IO_OE,
   // Mode bits from the status logic
   input wire logic I_BUF_MODE,
   input wire logic I_WP_EN,
   // Data buffer read port
   output logic O_BUF_RD,
   output logic [11:0] O_BUF_ADDR,
   input wire logic [7:0] I_BUF_DATA,
   output logic O_PAGE_NEXT,
   // Command status
   output logic O_ACTIVE,
   output logic O_REJECT
);
   // Dummy counts of zero would wrap the counter and give 128 dummy clocks
   if (P_BUF_BYTES < 1 || P_BUF_BYTES > SBFR_ADDR_SPAN)
   begin : g_bad_size
      $error("Buffer size does not fit the 12-bit address");
   end
   if (P_DIO_DUM_BUF == 7'h0 || P_DIO_DUM_SEQ == 7'h0 || P_DIO4_DUM_BUF == 7'h0 ||
       P_DIO4_DUM_SEQ == 7'h0 || P_QIO_DUM_BUF == 7'h0 || P_QIO_DUM_SEQ == 7'h0)
   begin : g_bad_dummy
      $error("Dummy clock counts must be at least one");
   end

   logic sclk_s1, sclk_s2, sclk_d;
   logic cs_s1, cs_s2;
   logic [3:0] io_s1, io_s2;
   sbfr_state_t state;
   logic [7:0] opc;
   logic [6:0] cnt;
   logic [15:0] col;
   logic mode_buf;
   logic [2:0] alanes;
   logic [2:0] dlanes;
   logic [4:0] aclks;
   logic [6:0] dums;
   logic [11:0] addr;
   logic end_flag;
   logic [2:0] bcnt;
   logic rd_q;
   logic [7:0] nbyte;

   sbfr_shift_if sh_if ();

   // Link clock sampled by the system clock, so it must stay well below half its rate
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end
      else
      begin
         sclk_s1 <= I_SCLK;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         cs_s1 <= I_CS_N;
         cs_s2 <= cs_s1;
         io_s1 <= I_IO;
         io_s2 <= io_s1;
      end
   end

   wire rise = ~cs_s2 & sclk_s2 & ~sclk_d;
   wire fall = ~cs_s2 & ~sclk_s2 & sclk_d;
   wire [7:0] next_opc = {opc[6:0], io_s2[0]};
   wire [6:0] cnt_next = cnt + 7'h1;

   // Opcode decode
   wire op_fr = (next_opc == SBFR_OP_FR);
   wire op_fr4 = (next_opc == SBFR_OP_FR4);
   wire op_do = (next_opc == SBFR_OP_DO);
   wire op_do4 = (next_opc == SBFR_OP_DO4);
   wire op_qo = (next_opc == SBFR_OP_QO);
   wire op_qo4 = (next_opc == SBFR_OP_QO4);
   wire op_dio = (next_opc == SBFR_OP_DIO);
   wire op_dio4 = (next_opc == SBFR_OP_DIO4);
   wire op_qio = (next_opc == SBFR_OP_QIO);
   wire dec_known = op_fr | op_fr4 | op_do | op_do4 | op_qo | op_qo4 | op_dio | op_dio4 | op_qio;
   wire dec_quad = op_qo | op_qo4 | op_qio;
   wire dec_reject = ~dec_known | (dec_quad & I_WP_EN);
   wire [2:0] dec_alanes = (op_dio | op_dio4) ? SBFR_LANES_2 :
                           op_qio ? SBFR_LANES_4 : SBFR_LANES_1;
   wire [2:0] dec_dlanes = (op_do | op_do4 | op_dio | op_dio4) ? SBFR_LANES_2 :
                           dec_quad ? SBFR_LANES_4 : SBFR_LANES_1;
   wire [4:0] dec_aclks = (dec_alanes == SBFR_LANES_4) ? SBFR_ACLK_4 :
                          (dec_alanes == SBFR_LANES_2) ? SBFR_ACLK_2 : SBFR_ACLK_1;
   wire [6:0] dec_dum_buf = (op_fr | op_do | op_qo) ? SBFR_DUM_BUF :
                            (op_fr4 | op_do4 | op_qo4) ? SBFR_DUM4_BUF :
                            op_dio ? P_DIO_DUM_BUF :
                            op_dio4 ? P_DIO4_DUM_BUF : P_QIO_DUM_BUF;
   wire [6:0] dec_dum_seq = (op_fr | op_do | op_qo) ? SBFR_DUM_SEQ :
                            (op_fr4 | op_do4 | op_qo4) ? SBFR_DUM4_SEQ :
                            op_dio ? P_DIO_DUM_SEQ :
                            op_dio4 ? P_DIO4_DUM_SEQ : P_QIO_DUM_SEQ;
   wire [6:0] dec_dums = I_BUF_MODE ? dec_dum_buf : dec_dum_seq;

   // Column bits arrive on as many lines as the address phase uses
   wire [15:0] next_col = (alanes == SBFR_LANES_4) ? {col[11:0], io_s2} :
                          (alanes == SBFR_LANES_2) ? {col[13:0], io_s2[1:0]} :
                          {col[14:0], io_s2[0]};
   wire addr_done = (cnt_next == {2'b00, aclks});
   wire dum_done = (cnt_next == dums);
   wire go_data = rise & (state == ST_DUMMY) & dum_done;

   // Command decoder; chip select high returns it to idle from any state
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         state <= ST_IDLE;
         opc <= 8'h00;
         cnt <= 7'h00;
         col <= 16'h0000;
         mode_buf <= 1'b0;
         alanes <= SBFR_LANES_1;
         dlanes <= SBFR_LANES_1;
         aclks <= SBFR_ACLK_1;
         dums <= SBFR_DUM_BUF;
         O_REJECT <= 1'b0;
         O_ACTIVE <= 1'b0;
      end
      else if (cs_s2)
      begin
         state <= ST_IDLE;
         cnt <= 7'h00;
         O_REJECT <= 1'b0;
         O_ACTIVE <= 1'b0;
      end
      else
      begin
         O_REJECT <= 1'b0;
         O_ACTIVE <= 1'b1;
         case (state)
            ST_IDLE:
            begin
               state <= ST_OPC;
               cnt <= 7'h00;
            end
            ST_OPC:
            begin
               if (rise)
               begin
                  opc <= next_opc;
                  cnt <= cnt_next;
                  if (cnt[2:0] == SBFR_OPC_LAST)
                  begin
                     cnt <= 7'h00;
                     mode_buf <= I_BUF_MODE;
                     alanes <= dec_alanes;
                     dlanes <= dec_dlanes;
                     aclks <= dec_aclks;
                     dums <= dec_dums;
                     state <= dec_reject ? ST_IGNORE : ST_ADDR;
                     O_REJECT <= dec_reject;
                  end
               end
            end
            ST_ADDR:
            begin
               if (rise)
               begin
                  col <= next_col;
                  cnt <= addr_done ? 7'h00 : cnt_next;
                  if (addr_done)
                  begin
                     state <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY:
            begin
               if (rise)
               begin
                  cnt <= cnt_next;
                  if (dum_done)
                  begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA, ST_IGNORE:
            begin
               state <= state;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Data phase selection
   wire in_data = (state == ST_DATA);
   wire at_boundary = in_data & fall & (bcnt == 3'h0);
   wire load_now = at_boundary & ~end_flag;
   wire hiz_now = at_boundary & end_flag;
   wire shift_now = in_data & fall & (bcnt != 3'h0);
   wire at_last = (addr == 12'(P_BUF_BYTES - 1));
   wire [11:0] addr_inc = addr + 12'h001;
   wire [11:0] start_addr = mode_buf ? col[11:0] : SBFR_ADDR_RST;
   wire start_past = mode_buf & (col >= 16'(P_BUF_BYTES));

   // Address walk and prefetch; the next byte is fetched while the current one shifts
   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         addr <= SBFR_ADDR_RST;
         end_flag <= 1'b0;
         bcnt <= 3'h0;
         O_BUF_RD <= 1'b0;
         O_BUF_ADDR <= SBFR_ADDR_RST;
         O_PAGE_NEXT <= 1'b0;
      end
      else if (cs_s2)
      begin
         end_flag <= 1'b0;
         bcnt <= 3'h0;
         O_BUF_RD <= 1'b0;
         O_PAGE_NEXT <= 1'b0;
      end
      else
      begin
         O_BUF_RD <= 1'b0;
         O_PAGE_NEXT <= 1'b0;
         if (go_data)
         begin
            addr <= start_addr;
            end_flag <= start_past;
            O_BUF_RD <= ~start_past;
            O_BUF_ADDR <= start_addr;
            bcnt <= 3'h0;
         end
         else if (load_now)
         begin
            bcnt <= dlanes;
            if (at_last && mode_buf)
            begin
               end_flag <= 1'b1;
            end
            else if (at_last)
            begin
               addr <= SBFR_ADDR_RST;
               O_BUF_RD <= 1'b1;
               O_BUF_ADDR <= SBFR_ADDR_RST;
               O_PAGE_NEXT <= 1'b1;
            end
            else
            begin
               addr <= addr_inc;
               O_BUF_RD <= 1'b1;
               O_BUF_ADDR <= addr_inc;
            end
         end
         else if (shift_now)
         begin
            bcnt <= bcnt + dlanes;
         end
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         rd_q <= 1'b0;
         nbyte <= SBFR_BYTE_RST;
      end
      else
      begin
         rd_q <= O_BUF_RD;
         if (rd_q)
         begin
            nbyte <= I_BUF_DATA;
         end
      end
   end

   assign sh_if.fall = shift_now;
   assign sh_if.load = load_now;
   assign sh_if.hiz = hiz_now;
   assign sh_if.stop = cs_s2;
   assign sh_if.byte_in = nbyte;
   assign sh_if.lanes = dlanes;

   sbfr_shifter u_shifter
   (
      .clk (I_MCLK),
      .rst (I_RST),
      .sh (sh_if.shf)
   );

   assign O_IO = sh_if.io_out;
   assign O_IO_OE = sh_if.io_oe;

   chk_cs_high_hiz:
   assert property (@(posedge I_MCLK) disable iff (I_RST) cs_s2 |=> (O_IO_OE == 4'h0))
      else $error("Output still driven after chip select high");

   chk_opc_rise_only:
   assert property (@(posedge I_MCLK) disable iff (I_RST) (state == ST_OPC && !rise) |=> $stable(opc))
      else $error("Opcode changed without a rising link clock");

   chk_single_msb_first:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (load_now && dlanes == SBFR_LANES_1) |=> (O_IO[1] == $past(nbyte[7]) && O_IO_OE == 4'h2))
      else $error("Single line byte did not start with its top bit");

   chk_dual_lanes:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (load_now && dlanes == SBFR_LANES_2) |=> (O_IO[1:0] == $past(nbyte[7:6]) && O_IO_OE == 4'h3))
      else $error("Dual output lanes wrong");

   chk_quad_lanes:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (load_now && dlanes == SBFR_LANES_4) |=> (O_IO == $past(nbyte[7:4]) && O_IO_OE == 4'hf))
      else $error("Quad output lanes wrong");

   chk_addr_step:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (load_now && !at_last) |=> (addr == $past(addr_inc) && O_BUF_RD && O_BUF_ADDR == addr))
      else $error("Buffer address did not advance after a byte");

   chk_end_hiz:
   assert property (@(posedge I_MCLK) disable iff (I_RST) hiz_now |=> (O_IO_OE == 4'h0) [*4])
      else $error("Output not released after the last buffer byte");

   chk_buf_start_col:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (go_data && mode_buf) |=> (addr == $past(col[11:0]) && end_flag == $past(start_past)))
      else $error("Buffer mode did not start at the column");

   chk_seq_start_zero:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (go_data && !mode_buf) |=> (addr == 12'h000 && O_BUF_RD))
      else $error("Sequential mode did not start at byte zero");

   chk_seq_page_wrap:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (load_now && at_last && !mode_buf) |=> (addr == 12'h000 && O_PAGE_NEXT && !end_flag))
      else $error("Sequential mode did not run into the next page");

   chk_wp_reject:
   assert property (@(posedge I_MCLK) disable iff (I_RST)
      (state == ST_OPC && rise && cnt[2:0] == SBFR_OPC_LAST && dec_quad && I_WP_EN && !cs_s2)
      |=> (state == ST_IGNORE && O_REJECT) ##1 (O_IO_OE == 4'h0))
      else $error("Quad read accepted under write protection");
endmodule : sbfr_top

/* inc/sbfr_pkg.sv */
// Overview of operation
// - 0Ch: column, then 24 or 40 dummies
// - Data leaves on falling edge, MSB first
// - Buffer address steps after every byte but the last one in buffer mode
// - Chip select high ends command, output stops
// - Buffer mode starts at column, stops at end
// - Buffer mode: Hi-Z after the last byte
// - Sequential mode starts at byte zero
// - Sequential mode runs into the next page
// - 3Bh outputs two bits per clock
// - 3Ch is 4-byte form of dual output
// - 6Bh outputs four bits per clock
// - 6Ch is 4-byte form of quad output
// - Write-protect enable rejects 6Bh, 6Ch, EBh
// - BBh takes address and dummies on two lines
// - BCh is 4-byte form of dual I/O
// - EBh uses four lines for address and data
// - 0Bh: column, then 8 or 32 dummies
// - Data buffer holds 2176 bytes
package sbfr_pkg;
   // Opcodes
   localparam logic [7:0] SBFR_OP_FR = 8'h0b;
   localparam logic [7:0] SBFR_OP_FR4 = 8'h0c;
   localparam logic [7:0] SBFR_OP_DO = 8'h3b;
   localparam logic [7:0] SBFR_OP_DO4 = 8'h3c;
   localparam logic [7:0] SBFR_OP_QO = 8'h6b;
   localparam logic [7:0] SBFR_OP_QO4 = 8'h6c;
   localparam logic [7:0] SBFR_OP_DIO = 8'hbb;
   localparam logic [7:0] SBFR_OP_DIO4 = 8'hbc;
   localparam logic [7:0] SBFR_OP_QIO = 8'heb;
   // Lane counts
   localparam logic [2:0] SBFR_LANES_1 = 3'h1;
   localparam logic [2:0] SBFR_LANES_2 = 3'h2;
   localparam logic [2:0] SBFR_LANES_4 = 3'h4;
   // Column address clocks per lane count
   localparam logic [4:0] SBFR_ACLK_1 = 5'h10;
   localparam logic [4:0] SBFR_ACLK_2 = 5'h08;
   localparam logic [4:0] SBFR_ACLK_4 = 5'h04;
   localparam logic [2:0] SBFR_OPC_LAST = 3'h7;
   // Dummy clocks of the single-line address forms
   localparam logic [6:0] SBFR_DUM_BUF = 7'h08;
   localparam logic [6:0] SBFR_DUM_SEQ = 7'h20;
   localparam logic [6:0] SBFR_DUM4_BUF = 7'h18;
   localparam logic [6:0] SBFR_DUM4_SEQ = 7'h28;
   // Default dummy clocks of the multi-line address forms
   localparam logic [6:0] SBFR_DIO_DUM_BUF = 7'h04;
   localparam logic [6:0] SBFR_DIO_DUM_SEQ = 7'h10;
   localparam logic [6:0] SBFR_DIO4_DUM_BUF = 7'h0c;
   localparam logic [6:0] SBFR_DIO4_DUM_SEQ = 7'h14;
   localparam logic [6:0] SBFR_QIO_DUM_BUF = 7'h02;
   localparam logic [6:0] SBFR_QIO_DUM_SEQ = 7'h08;
   // Data buffer size in bytes
   localparam int SBFR_BUF_BYTES = 2176;
   localparam int SBFR_ADDR_SPAN = 4096;
   // Reset values
   localparam logic [11:0] SBFR_ADDR_RST = 12'h000;
   localparam logic [7:0] SBFR_BYTE_RST = 8'h00;
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_OPC = 6'h02,
      ST_ADDR = 6'h04,
      ST_DUMMY = 6'h08,
      ST_DATA = 6'h10,
      ST_IGNORE = 6'h20
   } sbfr_state_t;
endpackage : sbfr_pkg

/* inc/sbfr_shift_if.sv */
interface sbfr_shift_if;
   logic fall;
   logic load;
   logic hiz;
   logic stop;
   logic [7:0] byte_in;
   logic [2:0] lanes;
   logic [3:0] io_out;
   logic [3:0] io_oe;
   modport ctl (output fall, load, hiz, stop, byte_in, lanes, input io_out, io_oe);
   modport shf (input fall, load, hiz, stop, byte_in, lanes, output io_out, io_oe);
endinterface : sbfr_shift_if

/* src/sbfr_shifter.sv */
module sbfr_shifter
   import sbfr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control from the decoder
   sbfr_shift_if.shf sh
);
   logic [7:0] sh_reg;
   wire [7:0] src;
   wire [7:0] next_sh;
   wire [3:0] next_out;
   wire [3:0] next_oe;

   assign src = sh.load ? sh.byte_in : sh_reg;
   assign next_sh = src << sh.lanes;
   // Single line data leaves on io_line_1, dual mode uses lines 1 and 0, quad mode all four lines
   assign next_out = (sh.lanes == SBFR_LANES_4) ? src[7:4] :
                     (sh.lanes == SBFR_LANES_2) ? {2'b00, src[7:6]} : {2'b00, src[7], 1'b0};
   assign next_oe = (sh.lanes == SBFR_LANES_4) ? 4'hf :
                    (sh.lanes == SBFR_LANES_2) ? 4'h3 : 4'h2;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sh_reg <= SBFR_BYTE_RST;
         sh.io_out <= 4'h0;
         sh.io_oe <= 4'h0;
      end
      else if (sh.stop || sh.hiz)
      begin
         sh.io_oe <= 4'h0;
      end
      else if (sh.load || sh.fall)
      begin
         sh_reg <= next_sh;
         sh.io_out <= next_out;
         sh.io_oe <= next_oe;
      end
   end
endmodule : sbfr_shifter

/* sim/sbfr_host_model.sv */
module sbfr_host
(
   // Link pins driven by the host
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   // Resolved lines and device enables
   input wire logic [3:0] io_in,
   input wire logic [3:0] dev_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // Link clock stands low between frames
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io_out = 4'h0;
      io_oe = 4'h0;
   end

   // One link clock: drive after the fall, sample on the rise
   task automatic clk_bit(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s, output logic seen);
      io_out = v;
      io_oe = oe;
      #62.5;
      sclk = 1'b1;
      s = io_in;
      seen = |dev_oe;
      #62.5;
      sclk = 1'b0;
   endtask : clk_bit

   task automatic read(input logic [7:0] op, input logic [15:0] col, input int al, input int nd, input int dl,
                       input int nb, output logic [7:0] d[$], output logic o[$]);
      logic [3:0] s;
      logic seen;
      logic any;
      logic [7:0] b;
      logic [3:0] mask;
      d = {};
      o = {};
      mask = (al == 1) ? 4'h1 : (al == 2) ? 4'h3 : 4'hf;
      // Chip select first, with time for the device to see it
      cs_n = 1'b0;
      #40;
      for (int k = 7; k >= 0; k--)
         clk_bit({3'h0, op[k]}, 4'h1, s, seen);
      for (int k = 16 - al; k >= 0; k -= al)
         clk_bit(4'(col >> k) & mask, mask, s, seen);
      // Lines released during dummies, as a real host would
      repeat (nd)
         clk_bit(4'h0, 4'h0, s, seen);
      repeat (nb)
      begin
         b = 8'h00;
         any = 1'b0;
         repeat (8 / dl)
         begin
            clk_bit(4'h0, 4'h0, s, seen);
            b = (b << dl) | ((dl == 1) ? {7'h00, s[1]} : (dl == 2) ? {6'h00, s[1:0]} : {4'h0, s});
            any |= seen;
         end
         d.push_back(b);
         o.push_back(any);
      end
      #40;
      io_oe = 4'h0;
      cs_n = 1'b1;
      #100;
   endtask : read
endmodule : sbfr_host

/* sim/serial_nand_buffer_fast_read_tb.sv */
module serial_nand_buffer_fast_read_tb;
   import sbfr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // Small buffer so the end and the wrap come quickly
   localparam int P = 16;
   typedef struct {logic [7:0] op; logic bm; logic wp; logic [15:0] col; int al; int nd; int dl; int nb;
                   int start; logic rej;} sbfr_row_t;

   logic I_MCLK = 1'b0;
   logic I_RST = 1'b1;
   logic I_BUF_MODE = 1'b1;
   logic I_WP_EN = 1'b0;
   logic [7:0] buf_data = 8'h00;
   logic [3:0] O_IO, O_IO_OE, host_out, host_oe, io_wire;
   logic cs_n, sclk, flt = 1'b0, rej_seen = 1'b0;
   logic O_BUF_RD, O_PAGE_NEXT, O_ACTIVE, O_REJECT;
   logic [11:0] O_BUF_ADDR;
   int page_cnt = 0;
   int error_cnt = 0;
   int checks_done = 0;
   // Bytes of the command cut by the mid-stream reset, never compared
   logic [7:0] cut_d[$];
   logic cut_o[$];

   always #5 I_MCLK = ~I_MCLK;

   // Released lines must not hold their last level, so they toggle
   always @(posedge I_MCLK) flt <= ~flt;
   assign io_wire = (O_IO_OE & O_IO) | (~O_IO_OE & host_oe & host_out) | (~O_IO_OE & ~host_oe & {4{flt}});

   function automatic logic [7:0] pat(input logic [11:0] a, input int pg);
      return (a[7:0] + 8'h31) ^ 8'(pg * 23);
   endfunction : pat

   // Buffer source answers the cycle after each request; it stands for a page already loaded
   always @(posedge I_MCLK)
   begin
      if (O_BUF_RD === 1'b1)
         buf_data <= #1 pat(O_BUF_ADDR, (O_PAGE_NEXT === 1'b1) ? page_cnt + 1 : page_cnt);
      if (O_PAGE_NEXT === 1'b1)
         page_cnt <= page_cnt + 1;
      if (O_REJECT === 1'b1)
         rej_seen <= 1'b1;
   end

   sbfr_top #(.P_BUF_BYTES(P)) u_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CS_N(cs_n), .I_SCLK(sclk),
      .I_IO(io_wire), .O_IO(O_IO), .O_IO_OE(O_IO_OE), .I_BUF_MODE(I_BUF_MODE), .I_WP_EN(I_WP_EN),
      .O_BUF_RD(O_BUF_RD), .O_BUF_ADDR(O_BUF_ADDR), .I_BUF_DATA(buf_data), .O_PAGE_NEXT(O_PAGE_NEXT),
      .O_ACTIVE(O_ACTIVE), .O_REJECT(O_REJECT));

   sbfr_host u_host (.cs_n(cs_n), .sclk(sclk), .io_out(host_out), .io_oe(host_oe), .io_in(io_wire),
      .dev_oe(O_IO_OE));

   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task automatic run(input sbfr_row_t r);
      logic [7:0] d[$];
      logic o[$];
      logic [11:0] a;
      int pg;
      @(posedge I_MCLK);
      #1;
      I_BUF_MODE = r.bm;
      I_WP_EN = r.wp;
      rej_seen = 1'b0;
      a = 12'(r.start);
      pg = page_cnt;
      u_host.read(r.op, r.col, r.al, r.nd, r.dl, r.nb, d, o);
      check("reject", 12'(rej_seen), 12'(r.rej));
      foreach (d[i])
      begin
         // Past the buffer end, or refused, nothing may be driven
         if (r.rej || (r.bm && a >= 12'(P)))
            check("drive off", 12'(o[i]), 12'h000);
         else
         begin
            check("drive on", 12'(o[i]), 12'h001);
            check("data", 12'(d[i]), 12'(pat(a, pg)));
         end
         a++;
         if (!r.bm && a == 12'(P))
         begin
            a = 12'h000;
            pg++;
         end
      end
      check("oe after cs", 12'(O_IO_OE), 12'h000);
      check("active after cs", 12'(O_ACTIVE), 12'h000);
   endtask : run

   sbfr_row_t rows[] = '{
      '{8'h0b, 1'b1, 1'b0, 16'h0003, 1, 8, 1, 3, 3, 1'b0},
      '{8'h0b, 1'b1, 1'b0, 16'h000e, 1, 8, 1, 4, 14, 1'b0},
      '{8'h0b, 1'b0, 1'b0, 16'h0007, 1, 32, 1, 18, 0, 1'b0},
      '{8'h0c, 1'b1, 1'b0, 16'h0005, 1, 24, 1, 2, 5, 1'b0},
      '{8'h0c, 1'b0, 1'b0, 16'h0009, 1, 40, 1, 2, 0, 1'b0},
      '{8'h3b, 1'b1, 1'b1, 16'h0002, 1, 8, 2, 3, 2, 1'b0},
      '{8'h3c, 1'b0, 1'b0, 16'h0009, 1, 40, 2, 2, 0, 1'b0},
      '{8'h6b, 1'b1, 1'b0, 16'h000d, 1, 8, 4, 4, 13, 1'b0},
      '{8'h6c, 1'b0, 1'b0, 16'h0004, 1, 40, 4, 17, 0, 1'b0},
      '{8'hbb, 1'b1, 1'b0, 16'h0006, 2, 4, 2, 2, 6, 1'b0},
      '{8'hbb, 1'b1, 1'b0, 16'h0014, 2, 4, 2, 2, 20, 1'b0},
      '{8'hbc, 1'b0, 1'b0, 16'h0003, 2, 20, 2, 2, 0, 1'b0},
      '{8'hbc, 1'b1, 1'b0, 16'h0008, 2, 12, 2, 2, 8, 1'b0},
      '{8'heb, 1'b1, 1'b0, 16'h000a, 4, 2, 4, 3, 10, 1'b0},
      '{8'heb, 1'b0, 1'b0, 16'h000a, 4, 8, 4, 2, 0, 1'b0},
      '{8'h6b, 1'b1, 1'b1, 16'h0000, 1, 8, 4, 1, 0, 1'b1},
      '{8'h6c, 1'b1, 1'b1, 16'h0000, 1, 24, 4, 1, 0, 1'b1},
      '{8'heb, 1'b1, 1'b1, 16'h0000, 4, 2, 4, 1, 0, 1'b1},
      '{8'h9f, 1'b1, 1'b0, 16'h0000, 1, 8, 1, 1, 0, 1'b1}};

   // Watchdog: all commands take about 15000 clocks, so 40000 leaves ample margin
   initial
   begin
      #400000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      repeat (5) @(posedge I_MCLK);
      #1;
      I_RST = 1'b0;
      check("addr at reset", O_BUF_ADDR, 12'h000);
      foreach (rows[i])
         run(rows[i]);
      // Reset in mid-stream must silence the pins at once
      fork
         u_host.read(8'h0b, 16'h0000, 1, 8, 1, 4, cut_d, cut_o);
         begin
            #5000;
            @(posedge I_MCLK);
            #1;
            I_RST = 1'b1;
            repeat (2) @(posedge I_MCLK);
            #1;
            check("oe in reset", 12'(O_IO_OE), 12'h000);
            check("active in reset", 12'(O_ACTIVE), 12'h000);
            check("addr in reset", O_BUF_ADDR, 12'h000);
            I_RST = 1'b0;
         end
      join
      // A clean command still works after the aborted one
      run(rows[0]);
      summarize();
   end
endmodule : serial_nand_buffer_fast_read_tb
